// File: include/sync_freeze_pkg.sv
package sync_freeze_pkg;

   // sizes
   localparam int NUM_SLOTS     = 8;
   localparam int SLOT_IDX_W    = 3;
   localparam int ADDR_W        = 12;
   localparam int GRP_FLAG_BIT  = 7;

   // register offsets (byte addresses)
   localparam logic [11:0] OFF_CONTROL   = 12'h000;
   localparam logic [11:0] OFF_STATUS    = 12'h004;
   localparam logic [11:0] OFF_LAST_CMD  = 12'h008;
   localparam logic [11:0] OFF_SLOT_BASE = 12'h020;
   localparam int          SLOT_IDX_LSB  = 2;
   localparam int          SLOT_SEL_LSB  = 5;

   // control word byte positions
   localparam int BYTE_GROUP_LSB   = 0;
   localparam int BYTE_STATION_LSB = 8;
   localparam int BYTE_CODE_LSB    = 16;
   localparam int BYTE_TRIGGER_LSB = 24;

   // slot word field positions
   localparam int SLOT_STATION_LSB = 0;
   localparam int SLOT_GROUP_LSB   = 8;
   localparam int SLOT_FLAGS_LSB   = 16;

   // status word field positions
   localparam int STAT_FROZEN_LSB = 0;
   localparam int STAT_SYNC_LSB   = 8;
   localparam int STAT_COUNT_LSB  = 16;
   localparam int STAT_BADCODE    = 24;

   // reset values
   localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
   localparam logic [18:0] SLOT_RESET    = 19'h0_0000;
   localparam logic [7:0]  COUNT_RESET   = 8'h00;

   // command encodings
   localparam logic [7:0] CODE_UNFREEZE     = 8'h01;
   localparam logic [7:0] CODE_FREEZE       = 8'h02;
   localparam logic [7:0] CODE_UNSYNC       = 8'h04;
   localparam logic [7:0] CODE_SYNC         = 8'h08;
   localparam logic [7:0] GROUP_GLOBAL      = 8'hff;
   localparam logic [6:0] STATION_BROADCAST = 7'h7f;
   localparam logic [3:0] GROUP_NONE        = 4'h0;
   localparam logic [3:0] GROUP_MAX         = 4'h8;

   typedef enum {ST_ARM, ST_WATCH} watch_state_t;

   typedef struct packed {
      logic [7:0] groupMask;
      logic [6:0] station;
      logic [7:0] code;
   } sf_cmd_t;

   typedef struct packed {
      logic [6:0] station;
      logic [3:0] groupNum;
      logic [7:0] opFlags;
   } slot_cfg_t;

   function automatic logic codeKnown(input logic [7:0] code);
      codeKnown = (code == CODE_UNFREEZE) || (code == CODE_FREEZE) ||
                  (code == CODE_UNSYNC) || (code == CODE_SYNC);
   endfunction : codeKnown

endpackage : sync_freeze_pkg

// File: design/trigger_watch.sv
`timescale 1ns/1ps
module trigger_watch (
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       reset_n,
   // trigger byte
   input  wire logic [7:0] triggerByte,
   output wire logic       triggerChanged
);

   sync_freeze_pkg::watch_state_t state;
   logic [7:0]                    refByte;

   // first cycle after reset only takes the reference
   assign triggerChanged = (state == sync_freeze_pkg::ST_WATCH) && (triggerByte != refByte);

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state   <= sync_freeze_pkg::ST_ARM;
         refByte <= 8'h00;
      end else begin
         case (state)
            sync_freeze_pkg::ST_ARM: begin
               refByte <= triggerByte;
               state   <= sync_freeze_pkg::ST_WATCH;
            end
            sync_freeze_pkg::ST_WATCH: begin
               if (triggerChanged) begin
                  refByte <= triggerByte;
               end
            end
            default: begin
               state <= sync_freeze_pkg::ST_ARM;
            end
         endcase
      end
   end

endmodule : trigger_watch

// File: design/slot_match.sv
`timescale 1ns/1ps
module slot_match (
   // slot setup and command
   input  wire sync_freeze_pkg::slot_cfg_t cfg,
   input  wire sync_freeze_pkg::sf_cmd_t   cmd,
   // result
   output wire logic                       selected
);

   logic       addrHit;
   logic       groupOk;
   logic       isGlobal;
   logic       grpEnabled;
   logic       grpInRange;
   logic [7:0] grpBit;

   assign addrHit    = (cmd.station == sync_freeze_pkg::STATION_BROADCAST) ||
                       (cmd.station == cfg.station);
   assign isGlobal   = (cmd.groupMask == sync_freeze_pkg::GROUP_GLOBAL);
   assign grpEnabled = cfg.opFlags[sync_freeze_pkg::GRP_FLAG_BIT];
   assign grpInRange = (cfg.groupNum != sync_freeze_pkg::GROUP_NONE) &&
                       (cfg.groupNum <= sync_freeze_pkg::GROUP_MAX);
   // mask bit n selects group n+1
   assign grpBit     = grpInRange ? (8'h01 << (cfg.groupNum - 4'h1)) : 8'h00;
   assign groupOk    = isGlobal || (grpEnabled && ((cmd.groupMask & grpBit) != 8'h00));
   assign selected   = addrHit && groupOk;

endmodule : slot_match

// File: design/sync_freeze_control_issuer.sv
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// - freeze makes selected slaves snapshot inputs together
// - frozen state held until unfreeze
// - sync makes selected slaves apply outputs together
// - outputs static until unsync or new sync
// - each further sync updates outputs
// - byte 0 mask: bit n is group n+1
// - group byte FFH means global group zero
// - byte 1 station address, 7FH broadcasts
// - code 01H unfreeze, 02H freeze
// - code 04H unsync, 08H sync
// - trigger byte change issues one command when the code is known
// - group control needs operating flag bit 7
module sync_freeze_control_issuer (
   // clock and reset
   input  wire logic                                   core_clk,
   input  wire logic                                   reset_n,
   // apb slave
   input  wire logic                                   psel,
   input  wire logic                                   penable,
   input  wire logic                                   pwrite,
   input  wire logic [11:0]                            paddr,
   input  wire logic [31:0]                            pwdata,
   output logic      [31:0]                            prdata,
   output logic                                        pready,
   output logic                                        pslverr,
   // global control command towards the fieldbus
   output logic                                        cmdValid,
   output sync_freeze_pkg::sf_cmd_t                    cmdOut,
   // per-slot effects
   output logic      [sync_freeze_pkg::NUM_SLOTS-1:0] freezeStrobe,
   output logic      [sync_freeze_pkg::NUM_SLOTS-1:0] syncStrobe,
   output logic      [sync_freeze_pkg::NUM_SLOTS-1:0] frozen,
   output logic      [sync_freeze_pkg::NUM_SLOTS-1:0] syncMode
);

   localparam int N = sync_freeze_pkg::NUM_SLOTS;

   // register storage
   logic [31:0]                 controlWord;
   sync_freeze_pkg::slot_cfg_t  slotCfg [N];
   sync_freeze_pkg::sf_cmd_t    cmdHeld;
   logic                        issuePending;
   logic [7:0]                  issueCount;
   logic                        badCode;

   // trigger watch
   logic                        triggerChanged;

   // apb decode
   wire logic                   setupPhase;
   wire logic                   accessDone;
   wire logic                   wrDone;
   wire logic                   hitControl;
   wire logic                   hitStatus;
   wire logic                   hitLastCmd;
   wire logic                   hitSlot;
   wire logic                   addrMapped;
   wire logic                   wrControl;
   wire logic                   wrStatus;
   wire logic                   wrSlot;
   wire logic [2:0]             slotIdx;
   wire logic [31:0]            statusWord;
   wire logic [31:0]            lastCmdWord;
   wire logic [31:0]            slotWord;
   wire logic [31:0]            readMux;
   wire sync_freeze_pkg::sf_cmd_t sampledCmd;

   // command decode
   wire logic [N-1:0]           selected;
   wire logic                   cmdKnown;
   wire logic                   doFreeze;
   wire logic                   doUnfreeze;
   wire logic                   doSync;
   wire logic                   doUnsync;

   assign setupPhase = psel && !penable;
   assign accessDone = psel && penable && pready;
   assign wrDone     = accessDone && pwrite;

   assign hitControl = (paddr == sync_freeze_pkg::OFF_CONTROL);
   assign hitStatus  = (paddr == sync_freeze_pkg::OFF_STATUS);
   assign hitLastCmd = (paddr == sync_freeze_pkg::OFF_LAST_CMD);
   assign hitSlot    = (paddr[11:sync_freeze_pkg::SLOT_SEL_LSB] ==
                        sync_freeze_pkg::OFF_SLOT_BASE[11:sync_freeze_pkg::SLOT_SEL_LSB]) &&
                       (paddr[1:0] == 2'h0);
   assign addrMapped = hitControl || hitStatus || hitLastCmd || hitSlot;
   assign slotIdx    = paddr[sync_freeze_pkg::SLOT_IDX_LSB +: sync_freeze_pkg::SLOT_IDX_W];

   assign wrControl  = wrDone && hitControl;
   assign wrStatus   = wrDone && hitStatus;
   assign wrSlot     = wrDone && hitSlot;

   assign statusWord = {7'h00,
                        badCode,
                        issueCount,
                        syncMode,
                        frozen};

   assign lastCmdWord = {8'h00,
                         cmdHeld.code,
                         1'b0,
                         cmdHeld.station,
                         cmdHeld.groupMask};

   assign slotWord = {8'h00,
                      slotCfg[slotIdx].opFlags,
                      4'h0,
                      slotCfg[slotIdx].groupNum,
                      1'b0,
                      slotCfg[slotIdx].station};

   assign readMux = hitControl ? controlWord :
                    hitStatus  ? statusWord  :
                    hitLastCmd ? lastCmdWord :
                    hitSlot    ? slotWord    :
                                 32'h0000_0000;

   // control bytes as they stand when the trigger moves
   assign sampledCmd.groupMask = controlWord[sync_freeze_pkg::BYTE_GROUP_LSB +: 8];
   assign sampledCmd.station   = controlWord[sync_freeze_pkg::BYTE_STATION_LSB +: 7];
   assign sampledCmd.code      = controlWord[sync_freeze_pkg::BYTE_CODE_LSB +: 8];

   assign cmdKnown   = sync_freeze_pkg::codeKnown(cmdHeld.code);
   assign doUnfreeze = issuePending && (cmdHeld.code == sync_freeze_pkg::CODE_UNFREEZE);
   assign doFreeze   = issuePending && (cmdHeld.code == sync_freeze_pkg::CODE_FREEZE);
   assign doUnsync   = issuePending && (cmdHeld.code == sync_freeze_pkg::CODE_UNSYNC);
   assign doSync     = issuePending && (cmdHeld.code == sync_freeze_pkg::CODE_SYNC);

   trigger_watch u_trigger_watch (
      .core_clk       (core_clk),
      .reset_n        (reset_n),
      .triggerByte    (controlWord[sync_freeze_pkg::BYTE_TRIGGER_LSB +: 8]),
      .triggerChanged (triggerChanged)
   );

   genvar gi;
   generate
      for (gi = 0; gi < N; gi++) begin : g_slot
         slot_match u_slot_match (
            .cfg      (slotCfg[gi]),
            .cmd      (cmdHeld),
            .selected (selected[gi])
         );
      end
   endgenerate

   // apb answer: no wait state, ready and data registered in the setup cycle
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= setupPhase;
         pslverr <= setupPhase && !addrMapped;
         prdata  <= (setupPhase && !pwrite) ? readMux : 32'h0000_0000;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         controlWord <= sync_freeze_pkg::CONTROL_RESET;
      end else if (wrControl) begin
         controlWord <= pwdata;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < N; i++) begin
            slotCfg[i] <= sync_freeze_pkg::SLOT_RESET;
         end
      end else if (wrSlot) begin
         slotCfg[slotIdx].station  <= pwdata[sync_freeze_pkg::SLOT_STATION_LSB +: 7];
         slotCfg[slotIdx].groupNum <= pwdata[sync_freeze_pkg::SLOT_GROUP_LSB +: 4];
         slotCfg[slotIdx].opFlags  <= pwdata[sync_freeze_pkg::SLOT_FLAGS_LSB +: 8];
      end
   end

   // capture the whole command in one edge with the trigger change
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cmdHeld      <= '0;
         issuePending <= 1'b0;
      end else begin
         issuePending <= triggerChanged;
         if (triggerChanged) begin
            cmdHeld <= sampledCmd;
         end
      end
   end

   // fieldbus command frame, one pulse per accepted change
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cmdValid <= 1'b0;
         cmdOut   <= '0;
      end else begin
         cmdValid <= issuePending && cmdKnown;
         if (issuePending && cmdKnown) begin
            cmdOut <= cmdHeld;
         end
      end
   end

   // bad code flag: a new bad code wins over the clear
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         badCode    <= 1'b0;
         issueCount <= sync_freeze_pkg::COUNT_RESET;
      end else begin
         if (issuePending && !cmdKnown) begin
            badCode <= 1'b1;
         end else if (wrStatus && pwdata[sync_freeze_pkg::STAT_BADCODE]) begin
            badCode <= 1'b0;
         end
         if (issuePending && cmdKnown) begin
            issueCount <= issueCount + 8'h01;
         end
      end
   end

   // per-slot freeze and sync state
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         freezeStrobe <= '0;
         syncStrobe   <= '0;
         frozen       <= '0;
         syncMode     <= '0;
      end else begin
         // all selected slots strobe on the same edge
         freezeStrobe <= doFreeze ? selected : '0;
         syncStrobe   <= doSync ? selected : '0;
         if (doFreeze) begin
            frozen <= frozen | selected;
         end else if (doUnfreeze) begin
            frozen <= frozen & ~selected;
         end
         if (doSync) begin
            syncMode <= syncMode | selected;
         end else if (doUnsync) begin
            syncMode <= syncMode & ~selected;
         end
      end
   end

endmodule : sync_freeze_control_issuer

// File: sim/slave_station_model.sv
`timescale 1ns/1ps
module slave_station_model (
   // clock and reset
   input  wire logic                                   core_clk,
   input  wire logic                                   reset_n,
   // command effects
   input  wire logic [sync_freeze_pkg::NUM_SLOTS-1:0] freezeStrobe,
   input  wire logic [sync_freeze_pkg::NUM_SLOTS-1:0] syncStrobe,
   // seen at the stations
   output logic      [7:0][7:0]                        snap,
   output logic      [7:0][7:0]                        applied
);
   // input level moves every cycle, so late snapshots differ
   logic [7:0] live;
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         live <= 8'h00;
         snap <= '0;
         applied <= '0;
      end else begin
         live <= live + 8'h01;
         for (int i = 0; i < 8; i++) begin
            if (freezeStrobe[i]) snap[i] <= live;
            if (syncStrobe[i]) applied[i] <= live;
         end
      end
   end
endmodule : slave_station_model

// File: sim/sync_freeze_chk.sv
`timescale 1ns/1ps
module sync_freeze_chk (
   // clock and reset
   input wire logic                                   core_clk,
   input wire logic                                   reset_n,
   // apb
   input wire logic                                   psel,
   input wire logic                                   penable,
   input wire logic                                   pready,
   input wire logic                                   pslverr,
   // command side
   input wire logic                                   cmdValid,
   input wire sync_freeze_pkg::sf_cmd_t               cmdOut,
   input wire logic [sync_freeze_pkg::NUM_SLOTS-1:0] freezeStrobe,
   input wire logic [sync_freeze_pkg::NUM_SLOTS-1:0] syncStrobe,
   input wire logic [sync_freeze_pkg::NUM_SLOTS-1:0] frozen,
   input wire logic [sync_freeze_pkg::NUM_SLOTS-1:0] syncMode
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   property p_ready; psel && !penable |=> pready; endproperty
   a_ready: assert property (p_ready) else $error("no ready after setup");
   property p_err; pslverr |-> pready; endproperty
   a_err: assert property (p_err) else $error("error without ready");
   property p_pulse; cmdValid |=> !cmdValid; endproperty
   a_pulse: assert property (p_pulse) else $error("command pulse too long");
   property p_frz; |freezeStrobe |-> cmdValid && cmdOut.code == sync_freeze_pkg::CODE_FREEZE
      && (frozen & freezeStrobe) == freezeStrobe; endproperty
   a_frz: assert property (p_frz) else $error("bad freeze strobe");
   property p_syn; |syncStrobe |-> cmdValid && cmdOut.code == sync_freeze_pkg::CODE_SYNC
      && (syncMode & syncStrobe) == syncStrobe; endproperty
   a_syn: assert property (p_syn) else $error("bad sync strobe");
   property p_frzHold; !cmdValid |-> $stable(frozen); endproperty
   a_frzHold: assert property (p_frzHold) else $error("frozen moved alone");
   property p_synHold; !cmdValid |-> $stable(syncMode); endproperty
   a_synHold: assert property (p_synHold) else $error("sync mode moved alone");
   property p_cmdHold; !cmdValid |-> $stable(cmdOut); endproperty
   a_cmdHold: assert property (p_cmdHold) else $error("command moved alone");
   property p_unfrz; cmdValid && cmdOut.code == sync_freeze_pkg::CODE_UNFREEZE
      |-> (frozen & ~$past(frozen)) == 8'h00; endproperty
   a_unfrz: assert property (p_unfrz) else $error("unfreeze froze a slot");
   property p_none; cmdValid && cmdOut.groupMask == 8'h00
      |-> freezeStrobe == 8'h00 && syncStrobe == 8'h00; endproperty
   a_none: assert property (p_none) else $error("empty mask selected");
endmodule : sync_freeze_chk
bind sync_freeze_control_issuer sync_freeze_chk chk (.core_clk, .reset_n, .psel, .penable,
   .pready, .pslverr, .cmdValid, .cmdOut, .freezeStrobe, .syncStrobe, .frozen, .syncMode);

// File: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic                     core_clk = 1'h0;
   logic                     reset_n  = 1'h0;
   logic                     psel     = 1'h0;
   logic                     penable  = 1'h0;
   logic                     pwrite   = 1'h0;
   logic [11:0]              paddr    = 12'h000;
   logic [31:0]              pwdata   = 32'h0000_0000;
   logic [31:0]              prdata;
   logic                     pready;
   logic                     pslverr;
   logic                     cmdValid;
   sync_freeze_pkg::sf_cmd_t cmdOut;
   logic [7:0]               freezeStrobe, syncStrobe, frozen, syncMode;
   logic [7:0][7:0]          snap, applied;
   logic [7:0]               trig = 8'h00, expFrz = 8'h00, expSyn = 8'h00, expCnt = 8'h00;
   logic                     expBad = 1'h0;
   logic [31:0]              q;
   logic                     e;
   logic [7:0]               app0;
   int                       n_mismatch = 0, n_compared = 0, cycles = 0;
   always #2.5 core_clk = ~core_clk;
   sync_freeze_control_issuer dut (.core_clk, .reset_n, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .cmdValid, .cmdOut, .freezeStrobe, .syncStrobe,
      .frozen, .syncMode);
   slave_station_model stations (.core_clk, .reset_n, .freezeStrobe, .syncStrobe, .snap,
      .applied);
   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : conclude
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         conclude();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      penable <= 1'h0;
      @(posedge core_clk);
      penable <= 1'h1;
      do @(posedge core_clk); while (pready !== 1'h1);
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   task automatic issue(input logic [7:0] m, input logic [6:0] s, input logic [7:0] c,
                        input logic bump);
      logic [7:0] sel;
      logic       ok;
      for (int i = 0; i < 8; i++) begin
         sel[i] = (s == 7'h7f || s == 7'(i + 1)) && (m == 8'hff || (i < 6 && m[i]));
      end
      ok = c == 8'h01 || c == 8'h02 || c == 8'h04 || c == 8'h08;
      if (bump) trig = trig + 8'h01;
      apb(1'h1, sync_freeze_pkg::OFF_CONTROL, {trig, c, 1'h0, s, m});
      repeat (2) @(posedge core_clk);
      #1;
      check(32'(cmdValid), 32'(bump && ok));
      if (bump && ok) begin
         check(32'(cmdOut), 32'({m, s, c}));
         check(32'(freezeStrobe), 32'(c == 8'h02 ? sel : 8'h00));
         check(32'(syncStrobe), 32'(c == 8'h08 ? sel : 8'h00));
         if (c == 8'h02) expFrz = expFrz | sel;
         if (c == 8'h01) expFrz = expFrz & ~sel;
         if (c == 8'h08) expSyn = expSyn | sel;
         if (c == 8'h04) expSyn = expSyn & ~sel;
         expCnt++;
      end
      if (bump && !ok) expBad = 1'h1;
      check({16'h0000, syncMode, frozen}, {16'h0000, expSyn, expFrz});
      @(posedge core_clk);
      #1;
      check(32'(cmdValid), 32'h0);
      apb(1'h0, sync_freeze_pkg::OFF_STATUS, 32'h0);
      check(q, {7'h00, expBad, expCnt, expSyn, expFrz});
      $display("test done: mask %h station %h code %h", m, s, c);
   endtask : issue
   initial begin
      repeat (5) @(posedge core_clk);
      reset_n <= 1'h1;
      apb(1'h0, sync_freeze_pkg::OFF_STATUS, 32'h0);
      check(q, 32'h0);
      apb(1'h0, 12'h010, 32'h0);
      check({q[30:0], e}, 32'h1);
      for (int i = 0; i < 8; i++) begin
         apb(1'h1, 12'h020 + 12'(4 * i), {8'h00, (i == 6) ? 8'h00 : 8'h80, 4'h0,
             (i == 7) ? 4'h0 : 4'(i + 1), 1'h0, 7'(i + 1)});
      end
      apb(1'h0, 12'h038, 32'h0);
      check(q, 32'h0000_0707);
      $display("test done: slot setup");
      issue(8'hff, 7'h7f, 8'h02, 1'h1);
      for (int i = 1; i < 8; i++) check(32'(snap[i]), 32'(snap[0]));
      check(32'(snap[0] != 8'h00), 32'h1);
      issue(8'hff, 7'h03, 8'h01, 1'h1);
      issue(8'h05, 7'h7f, 8'h08, 1'h1);
      app0 = applied[0];
      issue(8'h60, 7'h7f, 8'h08, 1'h1);
      check(32'(applied[0]), 32'(app0));
      issue(8'h05, 7'h7f, 8'h08, 1'h1);
      check(32'(applied[0] != app0), 32'h1);
      check(32'(applied[0]), 32'(applied[2]));
      issue(8'hff, 7'h7f, 8'h04, 1'h1);
      issue(8'hff, 7'h7f, 8'h03, 1'h1);
      issue(8'hff, 7'h7f, 8'h02, 1'h0);
      issue(8'h00, 7'h7f, 8'h02, 1'h1);
      apb(1'h0, sync_freeze_pkg::OFF_LAST_CMD, 32'h0);
      check(q, 32'h0002_7f00);
      apb(1'h1, sync_freeze_pkg::OFF_STATUS, 32'h0100_0000);
      expBad = 1'h0;
      apb(1'h0, sync_freeze_pkg::OFF_STATUS, 32'h0);
      check(q, {7'h00, expBad, expCnt, expSyn, expFrz});
      $display("test done: last command and flag clear");
      conclude();
   end
endmodule : tb_top
